// file: design/srp_device.sv
// Device end: serial slave into a register map port
`default_nettype none

module srp_device
  import srp_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Link
  srp_link_if.dev                    link,
  // Register map access
  output logic      [SRP_ADDR_W-1:0] reg_addr,
  output logic                       reg_wr,
  output logic      [SRP_DATA_W-1:0] reg_wdata,
  output logic                       reg_rd,
  input  wire logic [SRP_DATA_W-1:0] reg_rdata,
  // Optional ready indication on output line
  input  wire logic                  ready_mode_en,
  input  wire logic                  conv_ready
);

  // Decode below assumes this exact frame layout; refuse others
  if (SRP_FRAME_W != 1 + SRP_ADDR_W + SRP_DATA_W)
  begin : g_bad_frame
    $error("frame must hold direction, address and data");
  end
  if (int'(SRP_HDR_BITS) != 1 + SRP_ADDR_W)
  begin : g_bad_hdr
    $error("header must be direction plus address");
  end
  if (int'(SRP_LAST_BIT) != SRP_FRAME_W - 1)
  begin : g_bad_last
    $error("last bit index must close the frame");
  end
  if ((1 << SRP_CNT_W) <= SRP_FRAME_W)
  begin : g_bad_cnt
    $error("bit counter too narrow for the frame");
  end
  if (SRP_DIR_READ == SRP_DIR_WRITE)
  begin : g_bad_dir
    $error("read and write codes must differ");
  end

  // Two-flop synchronisers; stage one read only by stage two
  logic [2:0] s1_q, s1_d, s2_q, s2_d;
  logic       sclk_prev_q, sclk_prev_d;
  always_comb
  begin
    s1_d = {link.sclk, link.ss_n, link.mosi};
    s2_d = s1_q;
    sclk_prev_d = s2_q[2];
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      // Idle levels: clock low, select high, so no false edge
      s1_q        <= 3'h3;
      s2_q        <= 3'h3;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      s1_q        <= s1_d;
      s2_q        <= s2_d;
      sclk_prev_q <= sclk_prev_d;
    end
  end

  logic sclk_s, ss_s, mosi_s, rise, fall;
  assign sclk_s = s2_q[2];
  assign ss_s   = s2_q[1];
  assign mosi_s = s2_q[0];
  assign rise   = sclk_s & ~sclk_prev_q;
  assign fall   = ~sclk_s & sclk_prev_q;

  logic [SRP_FRAME_W-1:0] sr_q, sr_d;
  logic [SRP_CNT_W-1:0]   cnt_q, cnt_d;
  logic                   dir_q, dir_d;
  logic [SRP_ADDR_W-1:0]  addr_q, addr_d;
  logic [SRP_DATA_W-1:0]  tx_q, tx_d;
  logic                   out_q, out_d;
  logic                   wr_d, rd_d, wr_q, rd_q;
  logic [SRP_DATA_W-1:0]  wdata_q, wdata_d;
  logic                   rdy_prev_q, rdy_prev_d;
  logic                   rdy_pend_q, rdy_pend_d;

  always_comb
  begin
    sr_d       = sr_q;
    cnt_d      = cnt_q;
    dir_d      = dir_q;
    addr_d     = addr_q;
    tx_d       = tx_q;
    out_d      = out_q;
    wr_d       = 1'b0;
    rd_d       = 1'b0;
    wdata_d    = wdata_q;
    rdy_prev_d = conv_ready;
    rdy_pend_d = 1'b0;
    // Deselect wins over any edge seen in the same cycle
    if (ss_s)
    begin
      cnt_d = '0;
      out_d = 1'b1;
    end
    else if (rise)
    begin
      sr_d = {sr_q[SRP_FRAME_W-2:0], mosi_s};
      if (cnt_q == SRP_HDR_BITS - 5'h01)
      begin
        dir_d  = sr_q[SRP_ADDR_W-1];
        addr_d = {sr_q[SRP_ADDR_W-2:0], mosi_s};
        rd_d   = (sr_q[SRP_ADDR_W-1] == SRP_DIR_READ);
      end
      if (cnt_q == SRP_LAST_BIT)
      begin
        if (dir_q == SRP_DIR_WRITE)
        begin
          wr_d    = 1'b1;
          wdata_d = {sr_q[SRP_DATA_W-2:0], mosi_s};
        end
        addr_d = addr_q + 7'h01;
        cnt_d  = SRP_HDR_BITS;
        // Prefetch: a closing read touches one register past the last
        if (dir_q == SRP_DIR_READ)
          rd_d = 1'b1;
      end
      else
        cnt_d = cnt_q + 5'h01;
    end
    else if (fall && cnt_q >= SRP_HDR_BITS && dir_q == SRP_DIR_READ)
    begin
      out_d = tx_q[SRP_DATA_W-1];
      tx_d  = {tx_q[SRP_DATA_W-2:0], 1'b0};
    end
    else if (rdy_pend_q)
      out_d = 1'b0;
    else if (ready_mode_en && conv_ready && !rdy_prev_q)
    begin
      // Already low: pulse high first, so the host still sees a fall
      out_d      = ~out_q;
      rdy_pend_d = ~out_q;
    end
    // Read data is taken in the same cycle as the strobe
    if (rd_q)
      tx_d = reg_rdata;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sr_q       <= SRP_SR_RESET;
      cnt_q      <= '0;
      dir_q      <= SRP_DIR_WRITE;
      addr_q     <= '0;
      tx_q       <= '0;
      out_q      <= 1'b1;
      wr_q       <= 1'b0;
      rd_q       <= 1'b0;
      wdata_q    <= '0;
      rdy_prev_q <= 1'b0;
      rdy_pend_q <= 1'b0;
    end
    else
    begin
      sr_q       <= sr_d;
      cnt_q      <= cnt_d;
      dir_q      <= dir_d;
      addr_q     <= addr_d;
      tx_q       <= tx_d;
      out_q      <= out_d;
      wr_q       <= wr_d;
      rd_q       <= rd_d;
      wdata_q    <= wdata_d;
      rdy_prev_q <= rdy_prev_d;
      rdy_pend_q <= rdy_pend_d;
    end
  end

  // Write uses the address before increment, held for the strobe
  logic [SRP_ADDR_W-1:0] acc_addr_q, acc_addr_d;
  always_comb
  begin
    acc_addr_d = acc_addr_q;
    if (rd_d || wr_d)
      acc_addr_d = (cnt_q == SRP_LAST_BIT) ? ((dir_q == SRP_DIR_READ) ? addr_d : addr_q) : addr_d;
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      acc_addr_q <= '0;
    else
      acc_addr_q <= acc_addr_d;
  end

  assign reg_addr     = acc_addr_q;
  assign reg_wr       = wr_q;
  assign reg_rd       = rd_q;
  assign reg_wdata    = wdata_q;
  assign link.miso_o  = out_q;
  assign link.miso_oe = ~ss_s;

endmodule : srp_device

`default_nettype wire

// file: design/srp_pkg.sv
// Constants and types shared by both ends of the serial register port
`default_nettype none

package srp_pkg;
  localparam int          SRP_ADDR_W    = 7;
  localparam int          SRP_DATA_W    = 8;
  localparam int          SRP_FRAME_W   = 16;
  localparam int          SRP_CNT_W     = 5;
  localparam logic [4:0]  SRP_HDR_BITS  = 5'h08;
  localparam logic [4:0]  SRP_LAST_BIT  = 5'h0F;
  localparam logic        SRP_DIR_READ  = 1'b1;
  localparam logic        SRP_DIR_WRITE = 1'b0;
  // Host serial clock: half period in system clocks
  localparam int          SRP_HALF_DIV  = 4;
  localparam logic [2:0]  SRP_DIV_RESET = 3'h0;
  localparam logic [15:0] SRP_SR_RESET  = 16'h0000;

  typedef enum logic [2:0]
  {
    SRP_IDLE = 3'b000,
    SRP_SEL  = 3'b001,
    SRP_LOW  = 3'b010,
    SRP_HIGH = 3'b011,
    SRP_DONE = 3'b100
  } srp_host_state_t;
endpackage : srp_pkg

`default_nettype wire

// file: design/srp_link_if.sv
// Four-wire serial link joining host and device
`default_nettype none

interface srp_link_if;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  assign miso = miso_oe ? miso_o : 1'b1;

  modport host
  (
    output sclk,
    output ss_n,
    output mosi,
    input  miso
  );

  modport dev
  (
    input  sclk,
    input  ss_n,
    input  mosi,
    output miso_o,
    output miso_oe
  );
endinterface : srp_link_if

`default_nettype wire

// file: design/srp_host.sv
// Host end: serial master issuing register reads and writes
`default_nettype none

module srp_host
  import srp_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Link
  srp_link_if.host                   link,
  // Command port
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire logic                  cmd_read,
  input  wire logic [SRP_ADDR_W-1:0] cmd_addr,
  input  wire logic [SRP_DATA_W-1:0] cmd_wdata,
  input  wire logic                  cmd_more,
  output logic                       rsp_valid,
  output logic      [SRP_DATA_W-1:0] rsp_rdata
);

  srp_host_state_t        st_q, st_d;
  logic [2:0]             div_q, div_d;
  logic [SRP_CNT_W-1:0]   cnt_q, cnt_d;
  logic [SRP_FRAME_W-1:0] tx_q, tx_d;
  logic [SRP_DATA_W-1:0]  rx_q, rx_d;
  logic                   sclk_q, sclk_d, ss_q, ss_d, mosi_q, mosi_d;
  logic                   vld_q, vld_d;
  logic                   m1_q, m2_q;
  logic                   tick;

  // Returned data is asynchronous to this clock
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      m1_q <= 1'b1;
      m2_q <= 1'b1;
    end
    else
    begin
      m1_q <= link.miso;
      m2_q <= m1_q;
    end
  end

  assign tick      = (div_q == 3'(SRP_HALF_DIV - 1));
  assign cmd_ready = (st_q == SRP_IDLE) || (st_q == SRP_DONE);

  always_comb
  begin
    st_d   = st_q;
    div_d  = tick ? SRP_DIV_RESET : div_q + 3'h1;
    cnt_d  = cnt_q;
    tx_d   = tx_q;
    rx_d   = rx_q;
    sclk_d = sclk_q;
    ss_d   = ss_q;
    mosi_d = mosi_q;
    vld_d  = 1'b0;
    unique case (st_q)
      SRP_IDLE, SRP_DONE:
      begin
        if (cmd_valid)
        begin
          // New frame header only when freshly selected
          tx_d  = {cmd_read, cmd_addr, cmd_wdata};
          cnt_d = (st_q == SRP_DONE) ? SRP_HDR_BITS : '0;
          if (st_q == SRP_DONE)
            tx_d = {cmd_wdata, 8'h00};
          mosi_d = (st_q == SRP_DONE) ? cmd_wdata[SRP_DATA_W-1] : cmd_read;
          ss_d   = 1'b0;
          div_d  = SRP_DIV_RESET;
          st_d   = (st_q == SRP_DONE) ? SRP_LOW : SRP_SEL;
        end
        else if (st_q == SRP_DONE && tick)
        begin
          ss_d = 1'b1;
          st_d = SRP_IDLE;
        end
      end
      SRP_SEL:
        if (tick)
          st_d = SRP_LOW;
      SRP_LOW:
        if (tick)
        begin
          sclk_d = 1'b1;
          st_d   = SRP_HIGH;
        end
      SRP_HIGH:
        if (tick)
        begin
          sclk_d = 1'b0;
          // Late in the high phase: returned bit lags two flops
          rx_d   = {rx_q[SRP_DATA_W-2:0], m2_q};
          tx_d   = {tx_q[SRP_FRAME_W-2:0], 1'b0};
          mosi_d = tx_q[SRP_FRAME_W-2];
          if (cnt_q == SRP_LAST_BIT)
          begin
            vld_d = 1'b1;
            st_d  = SRP_DONE;
            if (!cmd_more)
              ss_d = 1'b1;
            if (!cmd_more)
              st_d = SRP_IDLE;
          end
          else
          begin
            cnt_d = cnt_q + 5'h01;
            st_d  = SRP_LOW;
          end
        end
      default:
        st_d = SRP_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q   <= SRP_IDLE;
      div_q  <= SRP_DIV_RESET;
      cnt_q  <= '0;
      tx_q   <= SRP_SR_RESET;
      rx_q   <= '0;
      sclk_q <= 1'b0;
      ss_q   <= 1'b1;
      mosi_q <= 1'b0;
      vld_q  <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      div_q  <= div_d;
      cnt_q  <= cnt_d;
      tx_q   <= tx_d;
      rx_q   <= rx_d;
      sclk_q <= sclk_d;
      ss_q   <= ss_d;
      mosi_q <= mosi_d;
      vld_q  <= vld_d;
    end
  end

  assign link.sclk = sclk_q;
  assign link.ss_n = ss_q;
  assign link.mosi = mosi_q;
  assign rsp_valid = vld_q;
  assign rsp_rdata = rx_q;

endmodule : srp_host

`default_nettype wire

// file: testbench/srp_checker.sv
// Assertions on the link between host and device ends
`default_nettype none

module srp_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rises_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Rising link edges within one selection
  always_ff @(posedge clk)
    if (!reset_n || ss_n)
      rises_q <= 8'h00;
    else if ($rose(sclk))
      rises_q <= rises_q + 8'h01;

  sequence s_high_half;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_lead;
    !sclk [*4];
  endsequence

  property p_idle_low; ss_n |-> !sclk; endproperty
  property p_release; ss_n [*4] |-> !miso_oe; endproperty
  property p_mosi_hold; sclk && $past(sclk) |-> $stable(mosi); endproperty
  property p_miso_hold;
    sclk && $past(sclk) && miso_oe && $past(miso_oe) |-> $stable(miso_o);
  endproperty
  property p_half; $rose(sclk) |-> s_high_half; endproperty
  property p_lead; $fell(ss_n) |-> s_lead; endproperty
  // Whole frames only: header plus whole bytes
  property p_frame; $rose(ss_n) |-> rises_q >= 8'h10 && rises_q[2:0] == 3'h0; endproperty
  property p_oe_sel; $rose(miso_oe) |-> !ss_n; endproperty

  a_idle_low:
    assert property (p_idle_low) else $error("link clock moved while deselected");
  a_release:
    assert property (p_release) else $error("output not released");
  a_mosi_hold:
    assert property (p_mosi_hold) else $error("host data changed while clock high");
  a_miso_hold:
    assert property (p_miso_hold) else $error("device data changed while clock high");
  a_half:
    assert property (p_half) else $error("clock high phase wrong length");
  a_lead:
    assert property (p_lead) else $error("clock came too soon after select");
  a_frame:
    assert property (p_frame) else $error("selection ended mid frame");
  a_oe_sel:
    assert property (p_oe_sel) else $error("device drove while deselected");
endmodule : srp_checker

`default_nettype wire

// file: testbench/spi_slave_register_port_bench.sv
// Bench: host and device joined, plus a hand-driven second device
`default_nettype none

module spi_slave_register_port_bench;
  import srp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk, reset_n, cmd_valid, cmd_ready, cmd_read, cmd_more;
  logic                  rsp_valid, reg_wr, reg_rd, wr2;
  logic [SRP_ADDR_W-1:0] cmd_addr, reg_addr, addr2;
  logic [SRP_DATA_W-1:0] cmd_wdata, rsp_rdata, reg_wdata, reg_rdata, wdata2, rsp_q;
  logic [15:0]           mosi_sr, miso_sr;
  logic [15:0]           wq[$];
  logic [15:0]           wq2[$];
  int                    n_fail = 0;
  int                    checked = 0;
  int                    cyc = 0;
  int                    n_rd = 0;
  logic                  rdy_en, conv_rdy;

  srp_link_if link();
  srp_link_if link_b();

  function automatic logic [7:0] rd_val(input logic [6:0] a);
    return {1'b1, a} ^ 8'h3C;
  endfunction : rd_val
  assign reg_rdata = rd_val(reg_addr);

  srp_host srp_host_i (.clk(clk), .reset_n(reset_n), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_more(cmd_more), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  srp_device srp_device_i (.clk(clk), .reset_n(reset_n), .link(link), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ready_mode_en(1'b0), .conv_ready(1'b0));
  srp_device srp_device_i2 (.clk(clk), .reset_n(reset_n), .link(link_b), .reg_addr(addr2),
    .reg_wr(wr2), .reg_wdata(wdata2), .reg_rd(), .reg_rdata(8'h00),
    .ready_mode_en(rdy_en), .conv_ready(conv_rdy));
  srp_checker srp_checker_i (.clk(clk), .reset_n(reset_n), .sclk(link.sclk), .ss_n(link.ss_n),
    .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Wire bits as seen by either end
  always @(posedge link.sclk)
  begin
    mosi_sr <= {mosi_sr[14:0], link.mosi};
    miso_sr <= {miso_sr[14:0], link.miso};
  end

  always @(posedge clk)
  begin
    if (reg_wr)
      wq.push_back({1'b0, reg_addr, reg_wdata});
    if (wr2)
      wq2.push_back({1'b0, addr2, wdata2});
    if (reg_rd)
      n_rd++;
    cyc++;
    // Whole run needs under a thousand cycles
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic send(input logic rd, input logic [6:0] a, input logic [7:0] d, input logic more);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_more <= more;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    while (rsp_valid !== 1'b1) @(negedge clk);
    rsp_q = rsp_rdata;
  endtask : send

  task automatic settle;
    @(negedge clk);
    while (link.ss_n !== 1'b1) @(negedge clk);
    repeat (6) @(negedge clk);
  endtask : settle

  // Stands in for a host that may break off mid frame
  task automatic bang(input logic [15:0] v, input int n);
    @(posedge clk);
    link_b.ss_n <= 1'b0;
    link_b.mosi <= v[15];
    for (int i = 15; i > 15 - n; i--)
    begin
      repeat (4) @(posedge clk);
      link_b.sclk <= 1'b1;
      repeat (4) @(posedge clk);
      link_b.sclk <= 1'b0;
      link_b.mosi <= (i > 0) ? v[i-1] : 1'b0;
    end
    repeat (4) @(posedge clk);
    link_b.ss_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : bang

  task automatic t_write;
    send(1'b0, 7'h12, 8'hA5, 1'b0);
    chk("deselect", 16'h0001, {15'h0000, link.ss_n});
    settle();
    chk("mosi bits", 16'h12A5, mosi_sr);
    chk("write", 16'h12A5, wq.pop_front());
    chk("miso idle", 16'h0001, {15'h0000, link.miso});
  endtask : t_write

  task automatic t_burst_write;
    send(1'b0, 7'h7E, 8'h11, 1'b1);
    send(1'b0, 7'h00, 8'h22, 1'b0);
    settle();
    chk("write 1", 16'h7E11, wq.pop_front());
    chk("write 2", 16'h7F22, wq.pop_front());
    chk("mosi data", 16'h1122, mosi_sr);
  endtask : t_burst_write

  task automatic t_burst_read;
    send(1'b1, 7'h05, 8'h00, 1'b1);
    chk("read 1", {8'h00, rd_val(7'h05)}, {8'h00, rsp_q});
    send(1'b1, 7'h00, 8'h00, 1'b0);
    chk("read 2", {8'h00, rd_val(7'h06)}, {8'h00, rsp_q});
    settle();
    chk("miso bits", {rd_val(7'h05), rd_val(7'h06)}, miso_sr);
    chk("no write", 16'h0000, 16'(wq.size()));
    chk("read strobes", 16'h0003, 16'(n_rd));
  endtask : t_burst_read

  task automatic t_abort;
    bang(16'h44F0, 12);
    bang(16'h335C, 16);
    chk("write count", 16'h0001, 16'(wq2.size()));
    chk("fresh frame", 16'h335C, wq2.pop_front());
    chk("released", 16'h0001, {15'h0000, link_b.miso});
  endtask : t_abort

  task automatic t_ready;
    @(posedge clk);
    rdy_en <= 1'b1;
    link_b.ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    conv_rdy <= 1'b1;
    repeat (4) @(posedge clk);
    chk("ready low", 16'h0000, {15'h0000, link_b.miso});
    link_b.ss_n <= 1'b1;
    conv_rdy <= 1'b0;
    repeat (4) @(posedge clk);
    rdy_en <= 1'b0;
    chk("ready released", 16'h0001, {15'h0000, link_b.miso});
  endtask : t_ready

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  initial
  begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 7'h00;
    cmd_wdata = 8'h00;
    cmd_more = 1'b0;
    link_b.sclk = 1'b0;
    link_b.ss_n = 1'b1;
    link_b.mosi = 1'b0;
    rdy_en = 1'b0;
    conv_rdy = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_write();
    t_burst_write();
    t_burst_read();
    t_ready();
    t_abort();
    test_done();
  end
endmodule : spi_slave_register_port_bench

`default_nettype wire
